/* common/atxcfg_pkg.sv */
// package: register map, field layout and types of the tx channel 6..8 slot configuration
package atxcfg_pkg;
  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CHANNEL6_CONFIG_OFS = 8'h23;
  localparam logic [7:0] TX_CHANNEL7_CONFIG_OFS = 8'h24;
  localparam logic [7:0] TX_CHANNEL8_CONFIG_OFS = 8'h25;
  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] TX_CHANNEL6_CONFIG_RST = 8'h05;
  localparam logic [7:0] TX_CHANNEL7_CONFIG_RST = 8'h06;
  localparam logic [7:0] TX_CHANNEL8_CONFIG_RST = 8'h07;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int SLOT_LSB = 0;
  localparam int SLOT_MSB = 4;
  localparam int SRC_LSB = 5;
  localparam int SRC_MSB = 6;
  localparam int CH8_SRC_BIT = 5;
  localparam int HALF_SLOT_BIT = 4; // right/left half in i2s and left-justified
  localparam logic [7:0] CH67_WRITE_MASK = 8'h7F; // bit 7 reserved
  localparam logic [7:0] CH8_WRITE_MASK = 8'h3F; // bits 7-6 reserved
  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ATX_SRC_TRISTATE = 2'b00,
    ATX_SRC_PRIMARY = 2'b01,
    ATX_SRC_SECONDARY = 2'b10,
    ATX_SRC_RESERVED = 2'b11
  } atx_src_e;
  typedef enum logic [1:0] {
    ATX_FMT_TDM = 2'b00,
    ATX_FMT_I2S = 2'b01,
    ATX_FMT_LJ = 2'b10
  } atx_fmt_e;
  // register write/read port
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } atx_reg_req_s;
  // frame position of the serial output
  typedef struct packed {
    logic slot_start;
    logic right_half;
    logic [4:0] slot;
  } atx_frame_pos_s;
endpackage

/* logic/atxcfg_slot_match.sv */
// module: matches one channel's slot field against the current frame position
`timescale 1ns/1ps
module atxcfg_slot_match
  import atxcfg_pkg::*;
(
  input wire logic [1:0] fmt,
  input wire atx_frame_pos_s pos,
  input wire logic [4:0] slot_field,
  output logic hit
);
  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  // lower four bits pick the slot within a half frame
  wire logic [3:0] half_index = slot_field[3:0];
  // upper bit picks which half
  wire logic want_right = slot_field[HALF_SLOT_BIT];
  // tdm compares all five bits directly
  wire logic tdm_hit = (pos.slot == slot_field); // R4
  // half-frame formats: 0..15 left, 16..31 right
  wire logic half_hit = (pos.slot[3:0] == half_index) && (pos.right_half == want_right); // R5 R6
  assign hit = (fmt == ATX_FMT_TDM) ? tdm_hit : half_hit;
endmodule // atxcfg_slot_match

/* logic/atxcfg_tx_slot_config.sv */
// module: tx channel 6..8 source selection and slot placement on the serial output
//
// Functional notes
// R1: channel 6 source: tristate, loopback, echo second
// R2: channel 7 source: tristate, battery/temp, echo pair
// R3: channel 8 bit 5: tristate or interchip data
// R4: tdm slot field selects slots 0 to 31
// R5: half formats: values 0-15 left slots
// R6: half formats: values 16-31 right slots
// R7: slot resets 5,6,7; sources reset tristate
// R8: reserved bits read zero, write zero only
// R9: tristate channel leaves output undriven all slot
`timescale 1ns/1ps
module atxcfg_tx_slot_config
  import atxcfg_pkg::*;
#(
  parameter int WORD_LEN = 32 // slot word length in bits
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire atx_reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [1:0] fmt,
  input wire atx_frame_pos_s pos,
  input wire logic [WORD_LEN-1:0] loopback_second,
  input wire logic [WORD_LEN-1:0] echo_reference_first,
  input wire logic [WORD_LEN-1:0] echo_reference_second,
  input wire logic [WORD_LEN/2-1:0] battery_half_word,
  input wire logic [WORD_LEN/2-1:0] temperature_half_word,
  input wire logic [WORD_LEN-1:0] interchip_link_data,
  output logic [WORD_LEN-1:0] slot_word,
  output logic slot_word_load,
  output logic sdout_oe
);
  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] tx_channel6_config; // source + slot, bit 7 reserved
  logic [7:0] tx_channel7_config; // source + slot, bit 7 reserved
  logic [7:0] tx_channel8_config; // source bit + slot, bits 7-6 reserved

  // write strobes from the register port
  wire logic wr6 = reg_req.wr && (reg_req.addr == TX_CHANNEL6_CONFIG_OFS);
  wire logic wr7 = reg_req.wr && (reg_req.addr == TX_CHANNEL7_CONFIG_OFS);
  wire logic wr8 = reg_req.wr && (reg_req.addr == TX_CHANNEL8_CONFIG_OFS);

  // reserved bits are masked on write so they can never read back as one
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tx_channel6_config <= TX_CHANNEL6_CONFIG_RST; // R7
      tx_channel7_config <= TX_CHANNEL7_CONFIG_RST; // R7
      tx_channel8_config <= TX_CHANNEL8_CONFIG_RST; // R7
    end else begin
      if (wr6) begin
        tx_channel6_config <= reg_req.wdata & CH67_WRITE_MASK; // R8
      end
      if (wr7) begin
        tx_channel7_config <= reg_req.wdata & CH67_WRITE_MASK; // R8
      end
      if (wr8) begin
        tx_channel8_config <= reg_req.wdata & CH8_WRITE_MASK; // R8
      end
    end
  end

  // ----------------------------------------------------------------
  // read back
  // ----------------------------------------------------------------
  // unmapped addresses read zero; read data is registered
  wire logic [7:0] next_rdata =
    (reg_req.addr == TX_CHANNEL6_CONFIG_OFS) ? tx_channel6_config :
    (reg_req.addr == TX_CHANNEL7_CONFIG_OFS) ? tx_channel7_config :
    (reg_req.addr == TX_CHANNEL8_CONFIG_OFS) ? tx_channel8_config : 8'h00;

  // read data holds until the next read
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire atx_src_e src6 = atx_src_e'(tx_channel6_config[SRC_MSB:SRC_LSB]);
  wire atx_src_e src7 = atx_src_e'(tx_channel7_config[SRC_MSB:SRC_LSB]);
  wire logic src8 = tx_channel8_config[CH8_SRC_BIT];
  wire logic hit6;
  wire logic hit7;
  wire logic hit8;

  // one matcher per channel; identical decode shared in a small module
  atxcfg_slot_match u_match6 (
    .fmt(fmt),
    .pos(pos),
    .slot_field(tx_channel6_config[SLOT_MSB:SLOT_LSB]),
    .hit(hit6)
  );
  atxcfg_slot_match u_match7 (
    .fmt(fmt),
    .pos(pos),
    .slot_field(tx_channel7_config[SLOT_MSB:SLOT_LSB]),
    .hit(hit7)
  );
  atxcfg_slot_match u_match8 (
    .fmt(fmt),
    .pos(pos),
    .slot_field(tx_channel8_config[SLOT_MSB:SLOT_LSB]),
    .hit(hit8)
  );

  // ----------------------------------------------------------------
  // source selection
  // ----------------------------------------------------------------
  // reserved source codes behave as tristate: safer than driving garbage
  wire logic act6 = hit6 && (src6 == ATX_SRC_PRIMARY || src6 == ATX_SRC_SECONDARY); // R1
  wire logic act7 = hit7 && (src7 == ATX_SRC_PRIMARY || src7 == ATX_SRC_SECONDARY); // R2
  wire logic act8 = hit8 && src8; // R3

  wire logic [WORD_LEN-1:0] word6 =
    (src6 == ATX_SRC_PRIMARY) ? loopback_second : echo_reference_second; // R1
  wire logic [WORD_LEN-1:0] word7 = (src7 == ATX_SRC_PRIMARY) ?
    {battery_half_word, temperature_half_word} : // R2
    {echo_reference_first[WORD_LEN-1 -: WORD_LEN/2],
     echo_reference_second[WORD_LEN-1 -: WORD_LEN/2]}; // R2

  // lowest channel wins if two share a slot; overlap is a software error
  wire logic [WORD_LEN-1:0] next_word =
    act6 ? word6 : act7 ? word7 : act8 ? interchip_link_data : '0;
  wire logic any_act = act6 || act7 || act8;

  // ----------------------------------------------------------------
  // slot output
  // ----------------------------------------------------------------
  // word and enable latched at slot start and held for the whole slot
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_word <= '0;
      sdout_oe <= 1'b0;
    end else if (pos.slot_start) begin
      slot_word <= next_word;
      sdout_oe <= any_act; // R9
    end
  end

  // load strobe for the shifter, only in slots actually driven
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slot_word_load <= 1'b0;
    end else begin
      slot_word_load <= pos.slot_start && any_act;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (rst)
    (tx_channel6_config[7] == 1'b0) && (tx_channel7_config[7] == 1'b0) &&
    (tx_channel8_config[7:6] == 2'b00)) // R8
    else $error("reserved config bit set");

  a_ch6_write: assert property (@(posedge ref_clk) disable iff (rst)
    wr6 |=> tx_channel6_config == ($past(reg_req.wdata) & CH67_WRITE_MASK)) // R1
    else $error("channel 6 config write lost");

  a_tristate_undriven: assert property (@(posedge ref_clk) disable iff (rst)
    pos.slot_start && !any_act |=> !sdout_oe) // R9
    else $error("output driven in tristate slot");

  a_ch6_word: assert property (@(posedge ref_clk) disable iff (rst)
    pos.slot_start && act6 && src6 == ATX_SRC_PRIMARY |=>
      sdout_oe && slot_word == $past(loopback_second)) // R1
    else $error("channel 6 loopback word wrong");

  a_ch7_pack: assert property (@(posedge ref_clk) disable iff (rst)
    pos.slot_start && !act6 && act7 && src7 == ATX_SRC_PRIMARY |=>
      slot_word == $past({battery_half_word, temperature_half_word})) // R2
    else $error("channel 7 battery word wrong");

  a_ch8_link: assert property (@(posedge ref_clk) disable iff (rst)
    pos.slot_start && hit8 && !src8 && !act6 && !act7 |=> !sdout_oe) // R3
    else $error("channel 8 driven while off");

  a_tdm_slot: assert property (@(posedge ref_clk) disable iff (rst)
    fmt == ATX_FMT_TDM && hit6 |-> pos.slot == tx_channel6_config[4:0]) // R4
    else $error("tdm slot mismatch");

  a_left_half: assert property (@(posedge ref_clk) disable iff (rst)
    fmt != ATX_FMT_TDM && hit7 && !tx_channel7_config[4] |-> !pos.right_half) // R5
    else $error("left half slot mismatch");

  a_right_half: assert property (@(posedge ref_clk) disable iff (rst)
    fmt != ATX_FMT_TDM && hit8 && tx_channel8_config[4] |->
      pos.right_half && pos.slot[3:0] == tx_channel8_config[3:0]) // R6
    else $error("right half slot mismatch");

  a_oe_holds: assert property (@(posedge ref_clk) disable iff (rst)
    !pos.slot_start |=> $stable(sdout_oe)) // R9
    else $error("output enable changed inside slot");

  a_reset_vals: assert property (@(posedge ref_clk)
    $fell(rst) |-> tx_channel7_config == TX_CHANNEL7_CONFIG_RST) // R7
    else $error("channel 7 reset value wrong");
endmodule // atxcfg_tx_slot_config

/* verification/atxcfg_host_model.sv */
// host side model: receives slot words from the serial data output
`timescale 1ns/1ps
module atxcfg_host_model
  import atxcfg_pkg::*;
#(
  parameter int WORD_LEN = 32 // slot word length in bits
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WORD_LEN-1:0] slot_word,
  input wire logic sdout_oe,
  output logic [WORD_LEN-1:0] line_word
);
  logic [WORD_LEN-1:0] last_word; // last value seen driven on the line
  // a released line shows the inverse, so a stale copy never passes for data
  assign line_word = sdout_oe ? slot_word : ~last_word;
  // remember what was driven last
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) last_word <= '0;
    else if (sdout_oe) last_word <= slot_word;
  end
endmodule // atxcfg_host_model

/* verification/tb_asi_tx_ch6_to_ch8_slot_config.sv */
// testbench: register access and slot placement of tx channels 6..8
`timescale 1ns/1ps
module tb_asi_tx_ch6_to_ch8_slot_config
  import atxcfg_pkg::*;
;
  logic ref_clk, rst, slot_word_load, sdout_oe;
  atx_reg_req_s reg_req;
  atx_frame_pos_s pos;
  logic [1:0] fmt;
  logic [7:0] reg_rdata;
  logic [31:0] lb, e1, e2, icl, slot_word, line_word;
  logic [15:0] bat, tmp;
  int err_total, samples_checked;
  atxcfg_tx_slot_config u_dut (.ref_clk(ref_clk), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .fmt(fmt), .pos(pos), .loopback_second(lb),
    .echo_reference_first(e1), .echo_reference_second(e2), .battery_half_word(bat),
    .temperature_half_word(tmp), .interchip_link_data(icl), .slot_word(slot_word),
    .slot_word_load(slot_word_load), .sdout_oe(sdout_oe));
  atxcfg_host_model u_host (.ref_clk(ref_clk), .rst(rst), .slot_word(slot_word),
    .sdout_oe(sdout_oe), .line_word(line_word));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one-cycle write pulse
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1 reg_req = '{1'b1, 1'b0, a, d};
    @(posedge ref_clk) #1 reg_req = '0;
  endtask
  // read data is valid one edge after the read pulse
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk) #1 reg_req = '{1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) #1 reg_req = '0;
    check({24'h0, reg_rdata}, {24'h0, exp});
  endtask
  // one slot start, then the driven flag, load pulse and host view
  task automatic slot(input logic [1:0] f, input logic rh, input logic [4:0] s,
      input logic eoe, input logic [31:0] ew);
    @(posedge ref_clk) #1 fmt = f;
    pos = '{1'b1, rh, s};
    @(posedge ref_clk) #1 pos.slot_start = 1'b0;
    check({30'h0, sdout_oe, slot_word_load}, {30'h0, eoe, eoe});
    if (eoe) check(line_word, ew);
  endtask
  task automatic test_done;
    $display("checks %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // watchdog: 2000 cycles, far above the well under 100 cycles the sequence needs
  initial begin
    #200000;
    err_total++;
    test_done;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    reg_req = '0;
    pos = '0;
    fmt = ATX_FMT_TDM;
    lb = 32'h1111_2222;
    e1 = 32'hA1A2_A3A4;
    e2 = 32'hB1B2_B3B4;
    icl = 32'hC0DE_5A5A;
    bat = 16'h3C3C;
    tmp = 16'h7E81;
    repeat (10) @(posedge ref_clk);
    #1 rst = 1'b0;
    rd(8'h23, 8'h05);
    rd(8'h24, 8'h06);
    rd(8'h25, 8'h07);
    rd(8'h26, 8'h00);
    slot(ATX_FMT_TDM, 1'b0, 5'd5, 1'b0, 32'h0);
    slot(ATX_FMT_TDM, 1'b0, 5'd6, 1'b0, 32'h0);
    slot(ATX_FMT_TDM, 1'b0, 5'd7, 1'b0, 32'h0);
    wr(8'h23, 8'h7F);
    rd(8'h23, 8'h7F);
    wr(8'h25, 8'h3F);
    rd(8'h25, 8'h3F);
    slot(ATX_FMT_TDM, 1'b0, 5'd31, 1'b1, icl);
    wr(8'h23, 8'h25);
    slot(ATX_FMT_TDM, 1'b0, 5'd5, 1'b1, lb);
    wr(8'h23, 8'h45);
    slot(ATX_FMT_TDM, 1'b0, 5'd5, 1'b1, e2);
    wr(8'h23, 8'h65);
    slot(ATX_FMT_TDM, 1'b0, 5'd5, 1'b0, 32'h0);
    wr(8'h24, 8'h26);
    slot(ATX_FMT_TDM, 1'b0, 5'd6, 1'b1, {bat, tmp});
    wr(8'h24, 8'h46);
    slot(ATX_FMT_TDM, 1'b0, 5'd6, 1'b1, {e1[31:16], e2[31:16]});
    slot(ATX_FMT_I2S, 1'b0, 5'd6, 1'b1, {e1[31:16], e2[31:16]});
    slot(ATX_FMT_I2S, 1'b1, 5'd6, 1'b0, 32'h0);
    wr(8'h23, 8'h34);
    slot(ATX_FMT_I2S, 1'b1, 5'd4, 1'b1, lb);
    slot(ATX_FMT_I2S, 1'b0, 5'd4, 1'b0, 32'h0);
    wr(8'h23, 8'h2F);
    slot(ATX_FMT_LJ, 1'b0, 5'd15, 1'b1, lb);
    slot(ATX_FMT_LJ, 1'b1, 5'd15, 1'b1, icl);
    slot(2'b11, 1'b1, 5'd15, 1'b1, icl);
    test_done;
  end
endmodule // tb_asi_tx_ch6_to_ch8_slot_config
